//--- rtl/fars_consts.vh
`ifndef FARS_CONSTS_VH
`define FARS_CONSTS_VH
// register byte offsets, one aligned word each
`define FARS_CTRL       8'h00
`define FARS_LIMIT      8'h04
`define FARS_HFREQ      8'h08
`define FARS_RIDE       8'h0c
`define FARS_SCUR       8'h10
`define FARS_SDEC       8'h14
`define FARS_MINBB      8'h18
`define FARS_VFF        8'h1c
`define FARS_VREC       8'h20
`define FARS_RINT       8'h24
`define FARS_STATUS     8'h28
`define FARS_IRQ_ST     8'h2c
`define FARS_IRQ_CLR    8'h30
`define FARS_IRQ_EN     8'h34
// control fields
`define FARS_CTRL_SEL_HI   2
`define FARS_CTRL_RIDE_BIT 3
`define FARS_SEL_HFREQ     3'h5
// trip input bit positions
`define FARS_T_CURRENT  0
`define FARS_T_BUSV     1
`define FARS_T_MOTLOAD  2
`define FARS_T_DRVLOAD  3
`define FARS_T_TORQUE   4
`define FARS_T_HOT      5
`define FARS_T_SAG      6
`define FARS_T_EARTH    7
// interrupt status bits
`define FARS_I_TRIP     0
`define FARS_I_GIVEUP   1
`define FARS_I_RESTART  2
`define FARS_I_CLEARED  3
// reset values
`define FARS_RST_LIMIT  8'h00
`define FARS_RST_MINBB  8'h05
`define FARS_RST_SDEC   8'h20
`define FARS_RST_VFF    8'h64
`define FARS_RST_VREC   8'h03
`define FARS_RST_SCUR   16'h0096
`define FARS_VF_FULL    8'h64
// timing: one tick is a tenth of a second
`define FARS_CLK_HZ        50000000
`define FARS_TICK_MS       100
`define FARS_TICK_CYC      (`FARS_CLK_HZ / 1000 * `FARS_TICK_MS)
`define FARS_FREE_MIN      10
`define FARS_FREE_TICKS    (`FARS_FREE_MIN * 60 * 1000 / `FARS_TICK_MS)
`endif

//--- rtl/fars_sync.v
`timescale 1ns/1ns
`default_nettype none
module fars_sync #(
  parameter W = 8
) (
  input  wire         clk_i,   // control clock
  input  wire         rst_i,   // sync reset
  input  wire [W-1:0] d_i,     // asynchronous pins
  output wire [W-1:0] q_o      // synchronised levels
);
  genvar g;
  // two flops per pin, the first one read only by the second
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      always @(posedge clk_i) begin
        if (rst_i) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= d_i[g];
          s2_q <= s1_q;
        end
      end
      assign q_o[g] = s2_q;
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/fars_tick.v
`timescale 1ns/1ns
`default_nettype none
module fars_tick #(
  parameter DIV = 5000000
) (
  input  wire clk_i,   // control clock
  input  wire rst_i,   // sync reset
  output reg  tick_o   // one-cycle pulse every DIV cycles
);
  reg [31:0] cnt_q;
  // free running divider, the tenth-second time base
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_q == DIV - 1) begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/fars_top.v
`timescale 1ns/1ns
`default_nettype none
`include "fars_consts.vh"
module fars_top #(
  parameter TICK_CYC = `FARS_TICK_CYC,
  parameter [7:0] RIDE_INIT = 8'h0a,
  parameter FW = 16
) (
  input  wire          clk_i,          // 50 MHz control clock
  input  wire          rst_i,          // sync reset, high
  input  wire          wb_cyc_i,       // wishbone cycle
  input  wire          wb_stb_i,       // wishbone strobe
  input  wire          wb_we_i,        // write enable
  input  wire [7:0]    wb_adr_i,       // byte address
  input  wire [3:0]    wb_sel_i,       // byte selects
  input  wire [31:0]   wb_dat_i,       // write data
  output reg  [31:0]   wb_dat_o,       // read data
  output reg           wb_ack_o,       // acknowledge
  input  wire [7:0]    trip_pins_i,    // trip detector pins
  input  wire          fault_reset_i,  // terminal/panel reset pin
  input  wire          stopping_i,     // ramp or dc brake stop pin
  input  wire [FW-1:0] out_freq_i,     // present output frequency
  input  wire [FW-1:0] out_current_i,  // present output current
  input  wire [FW-1:0] cmd_freq_i,     // commanded frequency
  output reg  [FW-1:0] freq_ref_o,     // frequency reference out
  output reg  [7:0]    vf_pct_o,       // V/f scale in percent
  output reg           baseblock_o,    // output stage blocked
  output reg           search_o,       // speed search running
  output reg           fault_o,        // fault contact
  output reg           relay_o,        // multi-function contact
  output reg  [7:0]    trip_disp_o,    // trip shown on panel
  output reg           irq_o           // level interrupt
);
  localparam ST_RUN     = 3'h0;
  localparam ST_BLOCK   = 3'h1;
  localparam ST_SEARCH  = 3'h2;
  localparam ST_RECOVER = 3'h3;
  localparam ST_FAULT   = 3'h4;

  wire [7:0] trip_s;
  wire [1:0] misc_s;
  wire       tick;

  fars_sync #(.W(10)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({stopping_i, fault_reset_i, trip_pins_i}),
    .q_o   ({misc_s, trip_s})
  );

  fars_tick #(.DIV(TICK_CYC)) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  wire stop_s  = misc_s[1];
  wire reset_s = misc_s[0];
  wire sag_s   = trip_s[`FARS_T_SAG];

  // configuration registers
  reg [2:0]    relay_function_select_q;
  reg          ride_enable_q;
  reg [7:0]    restart_attempt_limit_q;
  reg [FW-1:0] high_freq_detect_level_q;
  reg [7:0]    ride_through_time_q;
  reg [FW-1:0] search_current_level_q;
  reg [7:0]    search_decel_time_q;
  reg [7:0]    min_blocking_time_q;
  reg [7:0]    search_vf_factor_q;
  reg [7:0]    voltage_recovery_time_q;
  reg [7:0]    restart_interval_q;
  reg [3:0]    irq_en_q;
  reg [3:0]    irq_st_q;

  // sequencer state
  reg [2:0]    state_q;
  reg [7:0]    attempts_q;
  reg [7:0]    trip_code_q;
  reg [FW-1:0] held_freq_q;
  reg [FW-1:0] freq_q;
  reg [7:0]    vf_q;
  reg [23:0]   acc_q;
  reg [7:0]    blk_cnt_q;
  reg [7:0]    blk_len_q;
  reg [7:0]    ride_cnt_q;
  reg [15:0]   free_cnt_q;
  reg [3:0]    ev_q;

  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr_en   = bus_req & wb_ack_o & wb_we_i;

  // restartable trips exclude earth leakage
  wire [7:0] restartable = 8'h7f;
  wire       trip_any = |trip_s;
  wire       watch    = (state_q == ST_RUN) | (state_q == ST_SEARCH) |
                        (state_q == ST_RECOVER);
  wire       new_trip = watch & trip_any;
  wire       cur_or_v = trip_s[`FARS_T_CURRENT] | trip_s[`FARS_T_BUSV];

  // a trip that may not restart goes straight to the latched fault
  wire no_restart = (restart_attempt_limit_q == 8'h00) |
                    (stop_s & cur_or_v) |
                    (sag_s & ~ride_enable_q) |
                    (|(trip_s & ~restartable)) |
                    ({1'b0, attempts_q} + 9'h1 >
                     {1'b0, restart_attempt_limit_q});

  // spacing of attempts: the longer of interval and baseblock time
  wire [7:0] space_len = (restart_interval_q > min_blocking_time_q) ?
                         restart_interval_q : min_blocking_time_q;

  // wishbone register writes, taken at the edge that samples ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      relay_function_select_q  <= 3'h0;
      ride_enable_q            <= 1'b0;
      restart_attempt_limit_q  <= `FARS_RST_LIMIT;
      high_freq_detect_level_q <= {FW{1'b0}};
      ride_through_time_q      <= RIDE_INIT;
      search_current_level_q   <= `FARS_RST_SCUR;
      search_decel_time_q      <= `FARS_RST_SDEC;
      min_blocking_time_q      <= `FARS_RST_MINBB;
      search_vf_factor_q       <= `FARS_RST_VFF;
      voltage_recovery_time_q  <= `FARS_RST_VREC;
      restart_interval_q       <= 8'h00;
      irq_en_q                 <= 4'h0;
    end else if (wr_en && wb_sel_i[0]) begin
      if (wb_adr_i == `FARS_CTRL) begin
        relay_function_select_q <= wb_dat_i[`FARS_CTRL_SEL_HI:0];
        ride_enable_q           <= wb_dat_i[`FARS_CTRL_RIDE_BIT];
      end else if (wb_adr_i == `FARS_LIMIT) begin
        restart_attempt_limit_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == `FARS_HFREQ) begin
        high_freq_detect_level_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) begin
          high_freq_detect_level_q[15:8] <= wb_dat_i[15:8];
        end
      end else if (wb_adr_i == `FARS_RIDE) begin
        ride_through_time_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == `FARS_SCUR) begin
        search_current_level_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) begin
          search_current_level_q[15:8] <= wb_dat_i[15:8];
        end
      end else if (wb_adr_i == `FARS_SDEC) begin
        search_decel_time_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == `FARS_MINBB) begin
        min_blocking_time_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == `FARS_VFF) begin
        search_vf_factor_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == `FARS_VREC) begin
        voltage_recovery_time_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == `FARS_RINT) begin
        restart_interval_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == `FARS_IRQ_EN) begin
        irq_en_q <= wb_dat_i[3:0];
      end
    end
  end

  // one wait state: ack rises the cycle after the request, drops after
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= 32'h0;
      if (bus_req && !wb_ack_o && !wb_we_i) begin
        if (wb_adr_i == `FARS_CTRL) begin
          wb_dat_o <= {28'h0, ride_enable_q, relay_function_select_q};
        end else if (wb_adr_i == `FARS_LIMIT) begin
          wb_dat_o <= {24'h0, restart_attempt_limit_q};
        end else if (wb_adr_i == `FARS_HFREQ) begin
          wb_dat_o <= {16'h0, high_freq_detect_level_q};
        end else if (wb_adr_i == `FARS_RIDE) begin
          wb_dat_o <= {24'h0, ride_through_time_q};
        end else if (wb_adr_i == `FARS_SCUR) begin
          wb_dat_o <= {16'h0, search_current_level_q};
        end else if (wb_adr_i == `FARS_SDEC) begin
          wb_dat_o <= {24'h0, search_decel_time_q};
        end else if (wb_adr_i == `FARS_MINBB) begin
          wb_dat_o <= {24'h0, min_blocking_time_q};
        end else if (wb_adr_i == `FARS_VFF) begin
          wb_dat_o <= {24'h0, search_vf_factor_q};
        end else if (wb_adr_i == `FARS_VREC) begin
          wb_dat_o <= {24'h0, voltage_recovery_time_q};
        end else if (wb_adr_i == `FARS_RINT) begin
          wb_dat_o <= {24'h0, restart_interval_q};
        end else if (wb_adr_i == `FARS_STATUS) begin
          wb_dat_o <= {8'h0, trip_code_q, attempts_q, 5'h0, state_q};
        end else if (wb_adr_i == `FARS_IRQ_ST) begin
          wb_dat_o <= {28'h0, irq_st_q};
        end else if (wb_adr_i == `FARS_IRQ_EN) begin
          wb_dat_o <= {28'h0, irq_en_q};
        end
      end
    end
  end

  // sticky events: a set in the clearing cycle survives the clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q <= 4'h0;
      irq_o    <= 1'b0;
    end else begin
      if (wr_en && wb_sel_i[0] && wb_adr_i == `FARS_IRQ_CLR) begin
        irq_st_q <= (irq_st_q & ~wb_dat_i[3:0]) | ev_q;
      end else begin
        irq_st_q <= irq_st_q | ev_q;
      end
      irq_o <= |(irq_st_q & irq_en_q);
    end
  end

  // main sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= ST_RUN;
      attempts_q  <= 8'h00;
      trip_code_q <= 8'h00;
      held_freq_q <= {FW{1'b0}};
      freq_q      <= {FW{1'b0}};
      vf_q        <= `FARS_VF_FULL;
      acc_q       <= 24'h0;
      blk_cnt_q   <= 8'h00;
      blk_len_q   <= 8'h00;
      ride_cnt_q  <= 8'h00;
      free_cnt_q  <= 16'h0;
      ev_q        <= 4'h0;
    end else begin
      ev_q <= 4'h0;
      // fault-free time base; a trip restarts it, ten minutes clear count
      if (new_trip) begin
        free_cnt_q <= 16'h0;
      end else if (tick) begin
        if (free_cnt_q == `FARS_FREE_TICKS - 1) begin
          free_cnt_q <= 16'h0;
          if (attempts_q != 8'h00) begin
            ev_q[`FARS_I_CLEARED] <= 1'b1;
          end
          attempts_q <= 8'h00;
        end else begin
          free_cnt_q <= free_cnt_q + 16'h1;
        end
      end
      if (new_trip) begin
        trip_code_q           <= trip_s;
        held_freq_q           <= out_freq_i;
        ev_q[`FARS_I_TRIP]    <= 1'b1;
        blk_cnt_q             <= 8'h00;
        ride_cnt_q            <= 8'h00;
        if (no_restart) begin
          state_q              <= ST_FAULT;
          freq_q               <= {FW{1'b0}};
          ev_q[`FARS_I_GIVEUP] <= 1'b1;
        end else begin
          attempts_q <= attempts_q + 8'h01;
          blk_len_q  <= (attempts_q == 8'h00) ? min_blocking_time_q :
                        space_len;
          state_q    <= ST_BLOCK;
        end
      end else if (reset_s && state_q == ST_FAULT) begin
        // external reset releases the latched fault
        state_q     <= ST_RUN;
        attempts_q  <= 8'h00;
        trip_code_q <= 8'h00;
        vf_q        <= `FARS_VF_FULL;
      end else begin
        if (reset_s) begin
          attempts_q <= 8'h00;
        end
        case (state_q)
          ST_RUN: begin
            freq_q <= cmd_freq_i;
            vf_q   <= `FARS_VF_FULL;
          end
          ST_BLOCK: begin
            freq_q <= held_freq_q;
            if (tick && blk_cnt_q != 8'hff) begin
              blk_cnt_q <= blk_cnt_q + 8'h01;
            end
            // outage beyond ride-through turns into a latched sag fault
            if (tick && sag_s) begin
              ride_cnt_q <= ride_cnt_q + 8'h01;
              if (ride_cnt_q >= ride_through_time_q) begin
                state_q              <= ST_FAULT;
                freq_q               <= {FW{1'b0}};
                ev_q[`FARS_I_GIVEUP] <= 1'b1;
              end
            end
            // leave as soon as time is served and mains is back
            if (blk_cnt_q >= blk_len_q && !sag_s &&
                !(|(trip_s & ~(8'h1 << `FARS_T_SAG)))) begin
              trip_code_q           <= 8'h00;
              ev_q[`FARS_I_RESTART] <= 1'b1;
              acc_q                 <= 24'h0;
              freq_q                <= held_freq_q;
              if (search_decel_time_q == 8'h00) begin
                state_q <= ST_RECOVER;
                vf_q    <= 8'h00;
              end else begin
                state_q <= ST_SEARCH;
                vf_q    <= search_vf_factor_q;
              end
            end
          end
          ST_SEARCH: begin
            // lower frequency at held/decel per tick, one step per clock
            if (tick) begin
              acc_q <= acc_q + {8'h0, held_freq_q};
            end else if (acc_q >= {16'h0, search_decel_time_q} &&
                         freq_q != {FW{1'b0}}) begin
              acc_q  <= acc_q - {16'h0, search_decel_time_q};
              freq_q <= freq_q - {{(FW-1){1'b0}}, 1'b1};
            end
            // current below the level marks the sync point
            if (out_current_i < search_current_level_q ||
                freq_q == {FW{1'b0}}) begin
              state_q <= ST_RECOVER;
              acc_q   <= 24'h0;
            end
          end
          ST_RECOVER: begin
            freq_q <= cmd_freq_i;
            // rated voltage reached over the recovery time from zero
            if (voltage_recovery_time_q == 8'h00 ||
                vf_q >= `FARS_VF_FULL) begin
              vf_q    <= `FARS_VF_FULL;
              state_q <= ST_RUN;
            end else if (tick) begin
              acc_q <= acc_q + {16'h0, `FARS_VF_FULL};
            end else if (acc_q >= {16'h0, voltage_recovery_time_q}) begin
              acc_q <= acc_q - {16'h0, voltage_recovery_time_q};
              vf_q  <= vf_q + 8'h01;
            end
          end
          default: begin
            freq_q <= {FW{1'b0}};
          end
        endcase
      end
    end
  end

  // registered outputs, all but relay_o derived from the sequencer state
  always @(posedge clk_i) begin
    if (rst_i) begin
      freq_ref_o  <= {FW{1'b0}};
      vf_pct_o    <= `FARS_VF_FULL;
      baseblock_o <= 1'b0;
      search_o    <= 1'b0;
      fault_o     <= 1'b0;
      relay_o     <= 1'b0;
      trip_disp_o <= 8'h00;
    end else begin
      freq_ref_o  <= freq_q;
      vf_pct_o    <= vf_q;
      baseblock_o <= (state_q == ST_BLOCK) | (state_q == ST_FAULT);
      search_o    <= (state_q == ST_SEARCH);
      fault_o     <= (state_q == ST_FAULT);
      trip_disp_o <= trip_code_q;
      relay_o     <= (relay_function_select_q == `FARS_SEL_HFREQ) &&
                     (out_freq_i >= high_freq_detect_level_q);
    end
  end
endmodule
`default_nettype wire

//--- bench/fars_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "fars_consts.vh"
module fars_chk #(
  parameter FW = 16
) (
  input wire logic          clk_i,         // clock
  input wire logic          rst_i,         // reset
  input wire logic          wb_cyc_i,      // cycle
  input wire logic          wb_stb_i,      // strobe
  input wire logic          wb_we_i,       // write
  input wire logic [7:0]    wb_adr_i,      // address
  input wire logic [3:0]    wb_sel_i,      // lanes
  input wire logic [31:0]   wb_dat_i,      // write data
  input wire logic [31:0]   wb_dat_o,      // read data
  input wire logic          wb_ack_o,      // ack
  input wire logic [7:0]    trip_pins_i,   // trips
  input wire logic          fault_reset_i, // reset pin
  input wire logic          stopping_i,    // stop pin
  input wire logic [FW-1:0] out_freq_i,    // frequency
  input wire logic [FW-1:0] out_current_i, // current
  input wire logic [FW-1:0] cmd_freq_i,    // command
  input wire logic [FW-1:0] freq_ref_o,    // reference
  input wire logic [7:0]    vf_pct_o,      // v/f
  input wire logic          baseblock_o,   // blocked
  input wire logic          search_o,      // search
  input wire logic          fault_o,       // fault
  input wire logic          relay_o,       // relay
  input wire logic [7:0]    trip_disp_o,   // display
  input wire logic          irq_o          // interrupt
);
  logic [2:0]    sel_q;
  logic [FW-1:0] lvl_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // mirror the relay setup; commits on the ack edge like the slave
  always @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= 3'h0;
      lvl_q <= '0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      if (wb_adr_i == `FARS_CTRL && wb_sel_i[0]) sel_q <= wb_dat_i[2:0];
      if (wb_adr_i == `FARS_HFREQ && wb_sel_i[1:0] == 2'h3) lvl_q <= wb_dat_i[FW-1:0];
    end
  end
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  relay_level_a: assert property (
    relay_o == ($past(sel_q) == `FARS_SEL_HFREQ && $past(out_freq_i) >= $past(lvl_q)))
    else $error("relay contact wrong");
  trip_block_a: assert property (
    trip_pins_i != 8'h00 && !baseblock_o |-> ##[1:6] baseblock_o)
    else $error("trip did not block the output");
  fault_off_a: assert property (fault_o |-> baseblock_o && freq_ref_o == '0)
    else $error("fault left output running");
  fault_exit_a: assert property ($fell(fault_o) |-> $past(fault_reset_i, 4))
    else $error("fault left without reset");
  disp_held_a: assert property (baseblock_o |-> trip_disp_o != 8'h00)
    else $error("trip not shown while blocked");
  search_entry_a: assert property ($rose(search_o) |-> $past(baseblock_o))
    else $error("search began without baseblock");
  search_excl_a: assert property (search_o |-> !baseblock_o && !fault_o)
    else $error("search while blocked");
endmodule
bind fars_top fars_chk #(.FW(FW)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trip_pins_i(trip_pins_i),
  .fault_reset_i(fault_reset_i), .stopping_i(stopping_i), .out_freq_i(out_freq_i),
  .out_current_i(out_current_i), .cmd_freq_i(cmd_freq_i), .freq_ref_o(freq_ref_o),
  .vf_pct_o(vf_pct_o), .baseblock_o(baseblock_o), .search_o(search_o),
  .fault_o(fault_o), .relay_o(relay_o), .trip_disp_o(trip_disp_o), .irq_o(irq_o)
);
`default_nettype wire

//--- bench/fars_plant.sv
`timescale 1ns/1ns
`default_nettype none
module fars_plant (
  input  wire logic        clk_i,   // clock
  input  wire logic        rst_i,   // reset
  input  wire logic [15:0] ref_i,   // drive reference
  input  wire logic        block_i, // stage off
  input  wire logic        srch_i,  // search on
  output logic      [15:0] freq_o,  // output frequency
  output logic      [15:0] cur_o    // output current
);
  logic [15:0] speed_q;
  // shaft coasts down while blocked, holds during search, tracks the drive otherwise
  always @(posedge clk_i) begin
    if (rst_i) speed_q <= 16'h0;
    else if (block_i) speed_q <= speed_q - {15'h0, speed_q != 16'h0};
    else if (!srch_i) speed_q <= ref_i;
  end
  assign freq_o = ref_i;
  // searching above shaft speed draws heavy current until the two meet
  assign cur_o = !srch_i ? 16'h0080 : (ref_i > speed_q ? 16'h0200 : 16'h0010);
endmodule
`default_nettype wire

//--- bench/test_fault_auto_restart_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "fars_consts.vh"
module test_fault_auto_restart_sequencer;
  localparam int TICK = 10;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        frst = 1'b0;
  logic        stop = 1'b0;
  logic [3:0]  sel = 4'hf;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  trip = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [15:0] cmd = 16'h1000;
  logic [31:0] rd, rdat;
  logic [15:0] ofreq, ocur, fref;
  logic [7:0]  vf, disp;
  logic        ack, bb, srch, flt, rly, irq;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc_n = 0;
  int          i, n, a, t0;
  logic [7:0]  ra [0:10] = '{8'h04, 8'h18, 8'h14, 8'h1c, 8'h20, 8'h10, 8'h0c, 8'h24,
                             8'h28, 8'h30, 8'h3c};
  logic [31:0] rv [0:10] = '{32'h0, 32'h5, 32'h20, 32'h64, 32'h3, 32'h96, 32'ha, 32'h0,
                             32'h0, 32'h0, 32'h0};
  logic [31:0] fl [0:3] = '{32'h0, 32'h2, 32'h2, 32'h2};
  logic [31:0] fc [0:3] = '{32'hd, 32'hd, 32'h5, 32'hd};
  logic        fs [0:3] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [7:0]  fp [0:3] = '{8'h01, 8'h02, 8'h40, 8'h80};

  fars_top #(.TICK_CYC(TICK), .RIDE_INIT(8'h0a), .FW(16)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .trip_pins_i(trip), .fault_reset_i(frst), .stopping_i(stop), .out_freq_i(ofreq),
    .out_current_i(ocur), .cmd_freq_i(cmd), .freq_ref_o(fref), .vf_pct_o(vf),
    .baseblock_o(bb), .search_o(srch), .fault_o(flt), .relay_o(rly),
    .trip_disp_o(disp), .irq_o(irq));
  fars_plant plant (.clk_i(clk_i), .rst_i(rst_i), .ref_i(fref), .block_i(bb),
    .srch_i(srch), .freq_o(ofreq), .cur_o(ocur));

  always #10 clk_i = ~clk_i;
  // hang guard: the long idle wait dominates the run
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 75000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) bad_count++;
    rdat = rd;
    cyc <= 1'b0;
  endtask
  // pins held long enough to pass the two-stage synchroniser
  task automatic pin(input logic [7:0] t);
    trip <= t;
    wt(6);
    trip <= 8'h00;
  endtask
  task automatic clear_fault;
    frst <= 1'b1;
    wt(6);
    frst <= 1'b0;
    wt(6);
  endtask

  initial begin
    wt(5);
    rst_i <= 1'b0;
    wt(3);
    for (i = 0; i < 11; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(rdat, rv[i]);
    end
    bus(1'b1, `FARS_STATUS, 32'hff);
    bus(1'b0, `FARS_STATUS, 32'h0);
    chk(rdat, 32'h0);
    $display("test registers done");
    bus(1'b1, `FARS_HFREQ, 32'h1000);
    for (i = 0; i < 8; i++) begin
      bus(1'b1, `FARS_CTRL, 32'h8 | i);
      wt(3);
      chk(rly, i == 5);
    end
    bus(1'b1, `FARS_CTRL, 32'hd);
    cmd <= 16'h0fff;
    wt(4);
    chk(rly, 1'b0);
    cmd <= 16'h1000;
    wt(4);
    chk(rly, 1'b1);
    $display("test relay done");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `FARS_LIMIT, fl[i]);
      bus(1'b1, `FARS_CTRL, fc[i]);
      stop <= fs[i];
      wt(3);
      pin(fp[i]);
      chk(flt, 1'b1);
      chk(fref, 16'h0);
      chk(irq, 1'b0);
      stop <= 1'b0;
      clear_fault();
      chk(flt, 1'b0);
      bus(1'b0, `FARS_STATUS, 32'h0);
      chk(rdat[15:8], 8'h0);
    end
    $display("test no-restart cases done");
    bus(1'b1, `FARS_CTRL, 32'hd);
    bus(1'b1, `FARS_VFF, 32'h32);
    bus(1'b1, `FARS_RINT, 32'ha);
    bus(1'b1, `FARS_VREC, 32'h14);
    bus(1'b1, `FARS_IRQ_CLR, 32'hf);
    bus(1'b1, `FARS_IRQ_EN, 32'h7);
    for (a = 1; a <= 3; a++) begin
      t0 = cyc_n;
      pin(8'h01);
      chk(irq, 1'b1);
      if (a == 3) begin
        chk(flt, 1'b1);
      end else begin
        chk(disp, 8'h01);
        bus(1'b0, `FARS_STATUS, 32'h0);
        chk(rdat[15:8], a);
        while (bb !== 1'b0 && cyc_n - t0 < 1000) @(posedge clk_i);
        n = cyc_n - t0;
        chk(n >= (a == 1 ? 4 : 9) * TICK && n <= (a == 1 ? 6 : 11) * TICK + 12, 1'b1);
        chk(srch, 1'b1);
        chk(vf, 8'h32);
        for (n = 0; srch !== 1'b0 && n < 300; n++) @(posedge clk_i);
        for (n = 0; vf !== 8'h64 && n < 300; n++) @(posedge clk_i);
        chk(n >= 8 * TICK && n <= 12 * TICK, 1'b1);
        wt(2);
        chk(fref, cmd);
      end
    end
    bus(1'b0, `FARS_IRQ_ST, 32'h0);
    chk(rdat[2:0], 3'h7);
    bus(1'b1, `FARS_IRQ_CLR, 32'h7);
    wt(2);
    chk(irq, 1'b0);
    clear_fault();
    $display("test restart sequence done");
    bus(1'b1, `FARS_SDEC, 32'h0);
    pin(8'h01);
    a = 0;
    for (n = 0; (vf !== 8'h64 || bb !== 1'b0) && n < 500; n++) begin
      if (srch === 1'b1) a = 1;
      @(posedge clk_i);
    end
    chk(a, 0);
    chk(n < 500, 1'b1);
    wt(6000 * TICK + 50);
    bus(1'b0, `FARS_STATUS, 32'h0);
    chk(rdat[15:8], 8'h0);
    bus(1'b0, `FARS_IRQ_ST, 32'h0);
    chk(rdat[3], 1'b1);
    $display("test idle clear done");
    end_sim();
  end
endmodule
`default_nettype wire
